// >>> hw/trs_video_src.sv
`timescale 1ns/10ps
module trs_video_src
	import trs_ctrl_pkg::*;
#(
	parameter int H_TOTAL = 64,
	parameter int H_ACTIVE = 48,
	parameter int V_TOTAL = 20,
	parameter int V_BLANK = 4,
	parameter bit INTERLACED = 1'b1
) (
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	trs_link_if.source LINK,
	input wire logic H_TRS_MODE_IN,
	input wire logic JTAG_MODE_IN,
	input wire logic SDO_ENABLE_IN,
	input wire logic TEST_TMS_IN,
	input wire logic TEST_TCK_IN,
	input wire logic TEST_TDI_IN,
	output logic TEST_TDO_OUT,
	input wire logic REQ_IN,
	input wire logic REQ_WR_IN,
	input wire logic [11:0] REQ_ADDR_IN,
	input wire logic [15:0] REQ_WDATA_IN,
	output logic BUSY_OUT,
	output logic DONE_OUT,
	output logic [15:0] RDATA_OUT
);
	localparam int PIX_W = $clog2(H_TOTAL);
	localparam int LINE_W = $clog2(V_TOTAL);
	localparam int HALF_LINES = V_TOTAL / 2;

	typedef struct packed {
		logic [PIX_W-1:0] pix;
		logic [LINE_W-1:0] line;
		logic [9:0] word;
		logic xyz;
		logic h;
		logic v;
		logic f;
		logic h_cfg;
		host_state_e hst;
		logic [7:0] div;
		logic [5:0] bit_cnt;
		logic [31:0] frame;
		logic [15:0] rdata;
		logic [15:0] rdata_out;
		logic sclk;
		logic cs_n;
		logic sin;
		logic busy;
		logic done;
		logic mode;
		logic sdo_en;
		logic [1:0] sout_sy;
	} src_s;

	src_s s;
	src_s n;
	logic in_eav;
	logic in_sav;
	logic [1:0] ph;
	logic h_now;
	logic v_now;
	logic f_now;
	logic tick;

	// ==========================================================
	// Timing and video generation
	// ==========================================================
	always_comb begin
		n = s;
		in_eav = (int'(s.pix) >= H_ACTIVE) && (int'(s.pix) < H_ACTIVE + TRS_LEN);
		in_sav = int'(s.pix) >= H_TOTAL - TRS_LEN;
		ph = in_eav ? 2'(s.pix - PIX_W'(H_ACTIVE)) : 2'(s.pix - PIX_W'(H_TOTAL - TRS_LEN));
		f_now = INTERLACED && (int'(s.line) >= HALF_LINES);
		v_now = (int'(s.line) < V_BLANK) ||
			(INTERLACED && int'(s.line) >= HALF_LINES && int'(s.line) < HALF_LINES + V_BLANK);
		if (s.h_cfg) begin
			h_now = (int'(s.pix) >= H_ACTIVE) && !in_sav;
		end else begin
			h_now = int'(s.pix) >= H_ACTIVE;
		end
		n.h = h_now;
		n.v = v_now;
		n.f = f_now;
		n.xyz = (in_eav || in_sav) && ph == TRS_XYZ_PHASE;
		if (in_eav || in_sav) begin
			if (ph == TRS_ONES_PHASE) begin
				n.word = TRS_ONES;
			end else if (ph == TRS_XYZ_PHASE) begin
				n.word = make_xyz(f_now, v_now, in_eav);
			end else begin
				n.word = TRS_ZEROS;
			end
		end else if (int'(s.pix) < H_ACTIVE && !v_now) begin
			n.word = ACTIVE_LEVEL;
		end else begin
			n.word = BLANK_LEVEL;
		end
		if (int'(s.pix) == H_TOTAL - 1) begin
			// The horizontal timing choice is taken only at the end of a line, so a change
			// never splits a blanking pulse or raises it in the middle of a timing word.
			n.h_cfg = H_TRS_MODE_IN;
			n.pix = '0;
			n.line = (int'(s.line) == V_TOTAL - 1) ? '0 : LINE_W'(s.line + LINE_W'(1));
		end else begin
			n.pix = PIX_W'(s.pix + PIX_W'(1));
		end

		// ==========================================================
		// Serial host engine and test pass-through
		// ==========================================================
		n.sout_sy = {s.sout_sy[0], LINK.sout_line};
		n.sdo_en = SDO_ENABLE_IN;
		n.done = 1'b0;
		tick = s.div == 8'(SCLK_HALF_CYC - 1);
		n.div = (tick || s.hst == HS_IDLE) ? 8'h00 : 8'(s.div + 8'h01);
		case (s.hst)
			HS_IDLE: begin
				n.mode = JTAG_MODE_IN;
				if (s.mode) begin
					n.cs_n = TEST_TMS_IN;
					n.sclk = TEST_TCK_IN;
					n.sin = TEST_TDI_IN;
				end else begin
					n.cs_n = 1'b1;
					n.sclk = 1'b1;
					if (REQ_IN && !JTAG_MODE_IN) begin
						n.frame = {~REQ_WR_IN, CMD_PAD, REQ_ADDR_IN, REQ_WDATA_IN};
						n.cs_n = 1'b0;
						n.bit_cnt = '0;
						n.busy = 1'b1;
						n.hst = HS_HIGH;
					end
				end
			end
			HS_HIGH: begin
				if (tick) begin
					n.sclk = 1'b0;
					n.sin = s.frame[FRAME_BITS-1];
					n.frame = {s.frame[FRAME_BITS-2:0], 1'b0};
					n.hst = HS_LOW;
				end
			end
			HS_LOW: begin
				if (tick) begin
					n.sclk = 1'b1;
					n.rdata = {s.rdata[DATA_BITS-2:0], s.sout_sy[1]};
					n.bit_cnt = 6'(s.bit_cnt + 6'h01);
					n.hst = (s.bit_cnt == FRAME_LAST_BIT) ? HS_END : HS_HIGH;
				end
			end
			HS_END: begin
				if (tick) begin
					n.cs_n = 1'b1;
					n.done = 1'b1;
					n.busy = 1'b0;
					n.rdata_out = s.rdata;
					n.hst = HS_IDLE;
				end
			end
			default: begin
				n.hst = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			s <= '0;
			s.cs_n <= 1'b1;
			s.sclk <= 1'b1;
			s.sin <= 1'b1;
			s.sout_sy <= SYNC_IDLE_HIGH;
			s.hst <= HS_IDLE;
		end else begin
			s <= n;
		end
	end

	assign LINK.video_word = s.word;
	assign LINK.trs_xyz = s.xyz;
	assign LINK.h = s.h;
	assign LINK.v = s.v;
	assign LINK.f = s.f;
	assign LINK.mode_sel = s.mode;
	assign LINK.sdo_enable = s.sdo_en;
	assign LINK.cs_tms = s.cs_n;
	assign LINK.sclk_tck = s.sclk;
	assign LINK.sin_tdi = s.sin;
	assign TEST_TDO_OUT = s.sout_sy[1];
	assign BUSY_OUT = s.busy;
	assign DONE_OUT = s.done;
	assign RDATA_OUT = s.rdata_out;

endmodule

// >>> hw/trs_ctrl_pkg.sv
package trs_ctrl_pkg;

	// ==========================================================
	// Video word and TRS layout
	// ==========================================================
	localparam int WORD_W = 10;
	localparam logic [9:0] TRS_ONES = 10'h3FF;
	localparam logic [9:0] TRS_ZEROS = 10'h000;
	localparam logic [9:0] BLANK_LEVEL = 10'h040;
	localparam logic [9:0] ACTIVE_LEVEL = 10'h200;
	localparam int TRS_LEN = 4;
	localparam logic [1:0] TRS_XYZ_PHASE = 2'h3;
	localparam logic [1:0] TRS_ONES_PHASE = 2'h0;

	// ==========================================================
	// Serial host frame layout
	// ==========================================================
	localparam int CMD_BITS = 16;
	localparam int DATA_BITS = 16;
	localparam int FRAME_BITS = 32;
	localparam int CMD_RD_BIT = 15;
	localparam int ADDR_W = 12;
	localparam logic [5:0] CMD_LAST_BIT = 6'h0F;
	localparam logic [5:0] FRAME_LAST_BIT = 6'h1F;
	localparam logic [5:0] FRAME_END_CNT = 6'h20;
	localparam logic [2:0] CMD_PAD = 3'h0;

	// ==========================================================
	// Register map, field positions and reset values
	// ==========================================================
	localparam logic [11:0] REG_CFG_ADDR = 12'h000;
	localparam logic [11:0] REG_STAT_ADDR = 12'h001;
	localparam int CFG_HCFG_BIT = 0;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] CFG_WR_MASK = 16'h0001;
	localparam int STAT_PROC_BIT = 0;
	localparam int STAT_DET_BIT = 1;
	localparam int STAT_OE_BIT = 2;
	localparam int STAT_MODE_BIT = 3;
	localparam logic [1:0] SYNC_IDLE_HIGH = 2'h3;

	// ==========================================================
	// Serial clock timing
	// ==========================================================
	localparam int SYS_CLK_MHZ = 50;
	localparam int SCLK_HALF_NS = 160;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * SYS_CLK_MHZ) / 1000;

	typedef enum logic [1:0] {HS_IDLE, HS_HIGH, HS_LOW, HS_END} host_state_e;

	// Builds the XYZ word with its protection bits from F, V and H.
	function automatic logic [9:0] make_xyz(input logic f, input logic v, input logic h);
		make_xyz = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
	endfunction

endpackage

// >>> hw/trs_link_if.sv
`timescale 1ns/10ps
interface trs_link_if;
	logic [9:0] video_word;
	logic trs_xyz;
	logic h;
	logic v;
	logic f;
	logic mode_sel;
	logic sdo_enable;
	logic cs_tms;
	logic sclk_tck;
	logic sin_tdi;
	logic sout_tdo;
	logic sout_oe;
	logic sout_line;

	// The serial output line is pulled high when the device does not drive it.
	assign sout_line = sout_oe ? sout_tdo : 1'b1;

	modport device (
		input video_word, trs_xyz, h, v, f, mode_sel, sdo_enable, cs_tms, sclk_tck, sin_tdi,
		output sout_tdo, sout_oe
	);
	modport source (
		output video_word, trs_xyz, h, v, f, mode_sel, sdo_enable, cs_tms, sclk_tck, sin_tdi,
		input sout_line
	);
endinterface

// >>> hw/trs_flag_dev.sv
`timescale 1ns/10ps

module trs_flag_dev
	import trs_ctrl_pkg::*;
(
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	trs_link_if.device LINK,
	input wire logic TRS_DETECT_IN,
	input wire logic IO_PROC_EN_IN,
	input wire logic TAP_TDO_IN,
	output logic [9:0] VIDEO_OUT,
	output logic [1:0] SDO_OUT,
	output logic SDO_OE_OUT,
	output logic TAP_SEL_OUT,
	output logic TAP_TMS_OUT,
	output logic TAP_TCK_OUT,
	output logic TAP_TDI_OUT,
	output logic H_CONFIG_OUT
);

	typedef struct packed {
		logic [1:0] mode_sy;
		logic [1:0] oe_sy;
		logic [1:0] cs_sy;
		logic [1:0] sclk_sy;
		logic [1:0] sin_sy;
		logic [1:0] det_sy;
		logic [1:0] proc_sy;
		logic [1:0] tdo_sy;
		logic sclk_prev;
		logic [5:0] bit_cnt;
		logic [15:0] cmd;
		logic [15:0] shift_in;
		logic [15:0] shift_out;
		logic [15:0] cfg;
		logic sout;
		logic sout_oe;
		logic [9:0] video;
		logic [1:0] serial_digital_output;
		logic sdo_oe;
		logic tap_sel;
		logic tms;
		logic tck;
		logic tdi;
	} dev_s;

	dev_s s;
	dev_s n;
	logic host_mode;
	logic cs_act;
	logic sclk_rise;
	logic sclk_fall;
	logic flags_own;
	logic [15:0] cmd_now;
	logic [15:0] word_now;
	logic [9:0] word_out;

	// Read mux for the host interface. Unmapped addresses read as zero.
	function automatic logic [15:0] reg_read(input logic [11:0] addr, input dev_s st);
		logic [15:0] r;
		r = 16'h0000;
		if (addr == REG_CFG_ADDR) begin
			r = st.cfg;
		end else if (addr == REG_STAT_ADDR) begin
			r[STAT_PROC_BIT] = st.proc_sy[1];
			r[STAT_DET_BIT] = st.det_sy[1];
			r[STAT_OE_BIT] = st.oe_sy[1];
			r[STAT_MODE_BIT] = st.mode_sy[1];
		end
		reg_read = r;
	endfunction

	always_comb begin
		n = s;

		// ==========================================================
		// Pin synchronisers
		// ==========================================================
		// All shared and static pins come from outside this clock, so each passes two
		// flops; only the second stage is looked at by the logic below.
		n.mode_sy = {s.mode_sy[0], LINK.mode_sel};
		n.oe_sy = {s.oe_sy[0], LINK.sdo_enable};
		n.cs_sy = {s.cs_sy[0], LINK.cs_tms};
		n.sclk_sy = {s.sclk_sy[0], LINK.sclk_tck};
		n.sin_sy = {s.sin_sy[0], LINK.sin_tdi};
		n.det_sy = {s.det_sy[0], TRS_DETECT_IN};
		n.proc_sy = {s.proc_sy[0], IO_PROC_EN_IN};
		n.tdo_sy = {s.tdo_sy[0], TAP_TDO_IN};
		n.sclk_prev = s.sclk_sy[1];

		host_mode = ~s.mode_sy[1];
		cs_act = host_mode && !s.cs_sy[1];
		sclk_rise = s.sclk_sy[1] && !s.sclk_prev;
		sclk_fall = !s.sclk_sy[1] && s.sclk_prev;
		cmd_now = {s.shift_in[CMD_BITS-2:0], s.sin_sy[1]};
		word_now = {s.shift_in[DATA_BITS-2:0], s.sin_sy[1]};

		// ==========================================================
		// Shared pin routing and serial host interface
		// ==========================================================
		if (!host_mode) begin
			// Test mode: the pins belong to the boundary-scan port and the host
			// bit counter is cleared so a later switch back starts a new frame.
			n.tap_sel = 1'b1;
			n.tms = s.cs_sy[1];
			n.tck = s.sclk_sy[1];
			n.tdi = s.sin_sy[1];
			n.sout = s.tdo_sy[1];
			n.sout_oe = 1'b1;
			n.bit_cnt = '0;
		end else begin
			n.tap_sel = 1'b0;
			n.tms = 1'b0;
			n.tck = 1'b0;
			n.tdi = 1'b0;
			if (!cs_act) begin
				n.bit_cnt = '0;
				n.sout_oe = 1'b0;
				n.sout = 1'b1;
			end else if (sclk_rise && s.bit_cnt != FRAME_END_CNT) begin
				n.shift_in = word_now;
				n.bit_cnt = 6'(s.bit_cnt + 6'h01);
				if (s.bit_cnt == CMD_LAST_BIT) begin
					n.cmd = cmd_now;
					n.shift_out = reg_read(cmd_now[ADDR_W-1:0], s);
				end
				if (s.bit_cnt == FRAME_LAST_BIT && !s.cmd[CMD_RD_BIT]) begin
					if (s.cmd[ADDR_W-1:0] == REG_CFG_ADDR) begin
						n.cfg = word_now & CFG_WR_MASK;
					end
				end
			end else if (sclk_fall && s.cmd[CMD_RD_BIT] && s.bit_cnt > CMD_LAST_BIT &&
					s.bit_cnt != FRAME_END_CNT) begin
				// Data is changed on the falling edge so it is settled for the
				// host's rising-edge sample.
				n.sout = s.shift_out[DATA_BITS-1];
				n.shift_out = {s.shift_out[DATA_BITS-2:0], 1'b0};
				n.sout_oe = 1'b1;
			end else if (sclk_fall && s.bit_cnt == FRAME_END_CNT) begin
				n.sout_oe = 1'b0;
			end
		end

		// ==========================================================
		// TRS flag insertion and output stage
		// ==========================================================
		// The timing pins arrive with the video word on the same edge, so the XYZ
		// word is rebuilt from the values that travel with it.
		flags_own = !s.det_sy[1] && s.proc_sy[1];
		if (LINK.trs_xyz && flags_own) begin
			word_out = make_xyz(LINK.f, LINK.v, LINK.h);
		end else begin
			word_out = LINK.video_word;
		end
		n.video = word_out;
		n.sdo_oe = s.oe_sy[1];
		// The cable stage itself is not modelled; the pair carries the low bit in
		// true and complement form so the enable can be seen on a waveform.
		n.serial_digital_output = s.oe_sy[1] ? {~word_out[0], word_out[0]} : 2'b00;
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			s <= '0;
			s.cs_sy <= SYNC_IDLE_HIGH;
			s.sclk_sy <= SYNC_IDLE_HIGH;
			s.sin_sy <= SYNC_IDLE_HIGH;
			s.sclk_prev <= 1'b1;
			s.sout <= 1'b1;
			s.cfg <= CFG_RESET;
		end else begin
			s <= n;
		end
	end

	assign LINK.sout_tdo = s.sout;
	assign LINK.sout_oe = s.sout_oe;
	assign VIDEO_OUT = s.video;
	assign SDO_OUT = s.serial_digital_output;
	assign SDO_OE_OUT = s.sdo_oe;
	assign TAP_SEL_OUT = s.tap_sel;
	assign TAP_TMS_OUT = s.tms;
	assign TAP_TCK_OUT = s.tck;
	assign TAP_TDI_OUT = s.tdi;
	assign H_CONFIG_OUT = s.cfg[CFG_HCFG_BIT];

endmodule

// >>> verif/trs_flag_props.sv
`timescale 1ns/10ps
module trs_flag_props
	import trs_ctrl_pkg::*;
(
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic [9:0] video_word,
	input wire logic trs_xyz,
	input wire logic h,
	input wire logic mode_sel,
	input wire logic cs_tms,
	input wire logic sclk_tck,
	input wire logic sin_tdi,
	input wire logic sout_tdo,
	input wire logic sout_oe
);
	// ==========================================================
	// Helper state
	// ==========================================================
	// Host checks wait out the pin synchronisers after a mode change.
	logic [2:0] host_cnt_ff;
	logic [5:0] rise_cnt_ff;
	logic sclk_ff;

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN || mode_sel) host_cnt_ff <= 3'h0;
		else if (host_cnt_ff != 3'h7) host_cnt_ff <= host_cnt_ff + 3'h1;
		sclk_ff <= sclk_tck;
		if (RST_IN || cs_tms) rise_cnt_ff <= 6'h00;
		else if (sclk_tck && !sclk_ff) rise_cnt_ff <= rise_cnt_ff + 6'h01;
	end

	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (RST_IN);

	// ==========================================================
	// Properties
	// ==========================================================
	chk_idle_out_off: assert property ((!mode_sel && cs_tms) [*4] |-> !sout_oe)
		else $error("serial out driven while host not selected");
	chk_test_out_on: assert property (mode_sel [*4] |-> sout_oe)
		else $error("serial out not driven in test mode");
	chk_sclk_idle: assert property (host_cnt_ff == 3'h7 && cs_tms |-> sclk_tck)
		else $error("serial clock not idle high");
	chk_sin_on_low: assert property (host_cnt_ff == 3'h7 && !cs_tms && $changed(sin_tdi) |-> !sclk_tck)
		else $error("serial in moved while clock high");
	chk_sout_on_low: assert property (host_cnt_ff == 3'h7 && sout_oe && $past(sout_oe) && $changed(sout_tdo)
		|-> !sclk_tck)
		else $error("serial out moved while clock high");
	chk_frame_len: assert property (host_cnt_ff == 3'h7 && $fell(cs_tms) |-> ##[510:530] $rose(cs_tms))
		else $error("host frame length wrong");
	chk_bit_count: assert property (host_cnt_ff == 3'h7 && $rose(cs_tms) |-> rise_cnt_ff == 6'h20)
		else $error("host frame bit count wrong");
	chk_h_at_eav: assert property ($rose(h) |-> video_word == TRS_ONES)
		else $error("horizontal input rose away from timing word");
	chk_trs_order: assert property (trs_xyz |-> $past(video_word, 3) == TRS_ONES
		&& $past(video_word, 1) == TRS_ZEROS)
		else $error("timing word sequence broken");
endmodule

// >>> verif/trs_flag_and_control_pin_logic_bench.sv
`timescale 1ns/10ps
module trs_flag_and_control_pin_logic_bench
	import trs_ctrl_pkg::*;
;
	logic clk, rst, detect, proc, tdo_pin, h_mode, jtag, sdo_en, tms, tck, tdi, req, req_wr;
	logic [11:0] req_addr;
	logic [15:0] req_wdata, rdata, r;
	logic [9:0] video_out;
	logic [1:0] serial_digital_output;
	logic sdo_oe, tap_sel, tap_tms, tap_tck, tap_tdi, h_cfg, test_tdo, busy, done;
	int fail_count = 0;
	int compares = 0;
	int hl, vh, fh;

	trs_link_if trs_link_if_inst ();
	trs_video_src trs_video_src_inst (.SYS_CLK_IN(clk), .RST_IN(rst), .LINK(trs_link_if_inst), .H_TRS_MODE_IN(h_mode),
		.JTAG_MODE_IN(jtag), .SDO_ENABLE_IN(sdo_en), .TEST_TMS_IN(tms), .TEST_TCK_IN(tck), .TEST_TDI_IN(tdi),
		.TEST_TDO_OUT(test_tdo), .REQ_IN(req), .REQ_WR_IN(req_wr), .REQ_ADDR_IN(req_addr), .REQ_WDATA_IN(req_wdata),
		.BUSY_OUT(busy), .DONE_OUT(done), .RDATA_OUT(rdata));
	trs_flag_dev trs_flag_dev_inst (.SYS_CLK_IN(clk), .RST_IN(rst), .LINK(trs_link_if_inst), .TRS_DETECT_IN(detect),
		.IO_PROC_EN_IN(proc), .TAP_TDO_IN(tdo_pin), .VIDEO_OUT(video_out), .SDO_OUT(serial_digital_output), .SDO_OE_OUT(sdo_oe),
		.TAP_SEL_OUT(tap_sel), .TAP_TMS_OUT(tap_tms), .TAP_TCK_OUT(tap_tck), .TAP_TDI_OUT(tap_tdi),
		.H_CONFIG_OUT(h_cfg));
	trs_flag_props trs_flag_props_inst (.SYS_CLK_IN(clk), .RST_IN(rst), .video_word(trs_link_if_inst.video_word),
		.trs_xyz(trs_link_if_inst.trs_xyz), .h(trs_link_if_inst.h), .mode_sel(trs_link_if_inst.mode_sel),
		.cs_tms(trs_link_if_inst.cs_tms), .sclk_tck(trs_link_if_inst.sclk_tck), .sin_tdi(trs_link_if_inst.sin_tdi),
		.sout_tdo(trs_link_if_inst.sout_tdo), .sout_oe(trs_link_if_inst.sout_oe));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ==========================================================
	// Shared tasks
	// ==========================================================
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Compares %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask

	// The first argument asks for a read; the request pin itself is high for a write.
	task automatic host(input logic rd_op, input logic [11:0] addr, input logic [15:0] wd, output logic [15:0] rd);
		int i;
		@(negedge clk);
		req = 1'b1;
		req_wr = ~rd_op;
		req_addr = addr;
		req_wdata = wd;
		@(negedge clk);
		check(16'(busy), 16'h0001);
		req = 1'b0;
		for (i = 0; i < 1000 && done !== 1'b1; i++) @(negedge clk);
		if (i == 1000) begin
			fail_count++;
			tally_and_finish();
		end
		rd = rdata;
	endtask

	// Every output word is compared with the word and flags sampled one edge earlier.
	task automatic flags(input logic en);
		logic [9:0] w, e;
		logic x, hh, vv, ff;
		hl = 0;
		vh = 0;
		fh = 0;
		repeat (1280) begin
			@(posedge clk);
			w = trs_link_if_inst.video_word;
			x = trs_link_if_inst.trs_xyz;
			hh = trs_link_if_inst.h;
			vv = trs_link_if_inst.v;
			ff = trs_link_if_inst.f;
			e = (x && en) ? {1'b1, ff, vv, hh, vv ^ hh, ff ^ hh, ff ^ vv, ff ^ vv ^ hh, 2'b00} : w;
			if (x && !hh) hl++;
			if (x && vv) vh++;
			if (x && ff) fh++;
			@(negedge clk);
			check(16'(video_out), 16'(e));
		end
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic t_regs();
		host(1'b1, REG_CFG_ADDR, 16'h0000, r);
		check(r, CFG_RESET);
		host(1'b0, REG_CFG_ADDR, 16'hFFFF, r);
		host(1'b1, REG_CFG_ADDR, 16'h0000, r);
		check(r, 16'h0001);
		check(16'(h_cfg), 16'h0001);
		host(1'b1, 12'h123, 16'h0000, r);
		check(r, 16'h0000);
		host(1'b0, REG_CFG_ADDR, 16'h0000, r);
	endtask

	task automatic t_status();
		detect = 1'b1;
		proc = 1'b0;
		host(1'b1, REG_STAT_ADDR, 16'h0000, r);
		check(r, 16'h0006);
		check(16'({sdo_oe, serial_digital_output}), 16'({1'b1, ~video_out[0], video_out[0]}));
		sdo_en = 1'b0;
		cycles(5);
		check(16'({sdo_oe, serial_digital_output}), 16'h0000);
		sdo_en = 1'b1;
		detect = 1'b0;
		proc = 1'b1;
		cycles(5);
	endtask

	task automatic t_video();
		flags(1'b1);
		check(16'(hl), 16'h0000);
		check(16'(vh > 0), 16'h0001);
		check(16'(fh > 0), 16'h0001);
		h_mode = 1'b1;
		cycles(70);
		flags(1'b1);
		check(16'(hl), 16'h0014);
		h_mode = 1'b0;
		detect = 1'b1;
		cycles(70);
		flags(1'b0);
		detect = 1'b0;
		proc = 1'b0;
		cycles(5);
		flags(1'b0);
		proc = 1'b1;
	endtask

	task automatic t_test();
		jtag = 1'b1;
		cycles(8);
		check(16'(tap_sel), 16'h0001);
		for (int i = 0; i < 8; i++) begin
			{tms, tck, tdi} = 3'(i);
			tdo_pin = tms ^ tdi;
			cycles(10);
			check(16'({tap_tms, tap_tck, tap_tdi}), 16'(i));
			check(16'({trs_link_if_inst.sout_line, test_tdo}), 16'({tdo_pin, tdo_pin}));
		end
		req = 1'b1;
		cycles(20);
		check(16'(busy), 16'h0000);
		req = 1'b0;
		jtag = 1'b0;
		cycles(8);
		check(16'({tap_sel, tap_tms, tap_tck, tap_tdi}), 16'h0000);
		host(1'b1, REG_CFG_ADDR, 16'h0000, r);
		check(r, CFG_RESET);
	endtask

	initial begin
		rst = 1'b1;
		detect = 1'b0;
		proc = 1'b1;
		tdo_pin = 1'b0;
		h_mode = 1'b0;
		jtag = 1'b0;
		sdo_en = 1'b1;
		{tms, tck, tdi} = 3'h0;
		req = 1'b0;
		req_wr = 1'b0;
		req_addr = 12'h000;
		req_wdata = 16'h0000;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		cycles(4);
		t_regs();
		t_status();
		t_video();
		t_test();
		tally_and_finish();
	end
endmodule
